//--- logic/sbcs_bank_top.sv
// Summary of operation
// - Parity bits are XORs of data bit pairs; device recomputes and compares.
// - Write data lands only when recomputed parity matches received parity.
// - Bad parity or address discards data, keeps registers, sets error flag.
// - Address and R/W codes chosen so any single flipped bit is invalid.
// - Mode changes only when control and confirm registers hold equal codes.
// - Reset clears both mode registers and enters normal-request mode.
// - Codes 001 normal, 010 stand-by, 100 sleep, 111 emergency; read status.
// - Supply bit 0 switches output in normal/stand-by if cyclic, forced off.
// - Bit 1 cyclic sense in stand-by/sleep, bit 2 forced wake in sleep; cyclic wins.
// - Bit 3 links wake inputs to switched output; resets to one.
// - Supply control register returns to reset value under reset.
// - Three-bit wake period select, 32 ms to 8192 ms, default 32 ms.
// - Wake timing register cleared to default under reset.
// - Three-bit watchdog period select, 5 ms to 200 ms, default 5 ms.
// - Watchdog trigger accepted only in second half of the period.
// - Watchdog runs only in normal and stand-by modes.
// - Watchdog period register cleared to default under reset.
// - Ground register: threshold 1..0, shift flag bit 2, stuck flag bit 3.
// - Frame: address 15..10, R/W 9..8, parity 7..4, data 3..0.
// - Serial access only in normal-request, normal, stand-by modes.
// - MSB first; sample on fall, drive on rise; output off when deselected.
`default_nettype none
module sbcs_bank_top
#(
   parameter int unsigned MS_CYCLES = sbcs_pkg::MS_CYCLES
)
(
   // Clock and reset
   input  wire logic       MCLK,
   input  wire logic       RST_N,
   // Serial link
   input  wire logic       SCLK,
   input  wire logic       CS_N,
   input  wire logic       MOSI,
   output logic            MISO,
   output logic            MISO_OE,
   // Monitor inputs
   input  wire logic       GND_SHIFT,
   input  wire logic       TX_STUCK,
   // Mode and supply outputs
   output logic [2:0]      MODE,
   output logic            SWITCHED_OUTPUT_ON,
   output logic            CYCLIC_SENSE_ON,
   output logic            FORCED_WAKE_ON,
   output logic            WAKE_INPUTS_LINKED,
   output logic [2:0]      WAKE_PERIOD_SEL,
   output logic [1:0]      GND_THRESHOLD,
   // Events
   output logic            WDOG_RESET,
   output logic            SPI_WAKE,
   output logic            FRAME_ERROR
);
   import sbcs_pkg::*;

   sbcs_frame_if fr ();

   sbcs_mode_t  mode_q;
   logic [2:0]  mode_ctrl_q;
   logic [2:0]  mode_conf_q;
   logic [3:0]  supply_q;
   logic [2:0]  wake_tim_q;
   logic [2:0]  wdog_sel_q;
   logic [1:0]  gnd_thr_q;
   logic [1:0]  gnd_sync_q;
   logic [1:0]  txd_sync_q;
   logic        shift_q;
   logic        err_q;
   logic [5:0]  head_addr_q;
   logic        wd_expire;

   logic [5:0]  f_addr;
   logic [1:0]  f_rw;
   logic [3:0]  f_par;
   logic [3:0]  f_data;
   logic        f_ok;
   logic        f_wr;
   logic        f_rd;
   logic        f_err;
   logic [3:0]  rd_data;
   logic        mode_code_ok;

   ////////////////////////////////////////////////////////////////////////
   // Address and code checks
   function automatic logic addr_known(input logic [5:0] a);
      case (a)
         OFS_MODE_CONTROL,
         OFS_MODE_CONFIRM,
         OFS_SUPPLY_CTRL,
         OFS_WAKE_TIMING,
         OFS_WDOG_PERIOD,
         OFS_GND_MONITOR,
         OFS_FRAME_ERROR: addr_known = 1'b1;
         default:         addr_known = 1'b0;
      endcase
   endfunction

   assign f_addr = fr.frame_word[ADDR_MSB:ADDR_LSB];
   assign f_rw   = fr.frame_word[RW_MSB:RW_LSB];
   assign f_par  = fr.frame_word[PAR_MSB:PAR_LSB];
   assign f_data = fr.frame_word[DATA_MSB:DATA_LSB];

   // Valid offsets all have even weight, so one flipped bit is unknown
   assign f_ok  = (sbcs_parity(f_data) == f_par)
                & addr_known(f_addr)
                & ((f_rw == RW_WRITE) | (f_rw == RW_READ));
   assign f_wr  = fr.frame_done & f_ok & (f_rw == RW_WRITE);
   assign f_rd  = fr.frame_done & f_ok & (f_rw == RW_READ);
   assign f_err = (fr.frame_done & ~f_ok) | fr.frame_abort;

   assign mode_code_ok = (f_data[2:0] == SBCS_NORMAL)
                       | (f_data[2:0] == SBCS_STANDBY)
                       | (f_data[2:0] == SBCS_SLEEP)
                       | (f_data[2:0] == SBCS_EMERGENCY);

   ////////////////////////////////////////////////////////////////////////
   // Read path, loaded after the address byte
   always_comb
   begin
      case (fr.frame_word[7:2])
         OFS_MODE_CONTROL,
         OFS_MODE_CONFIRM: rd_data = {1'b0, mode_q};
         OFS_SUPPLY_CTRL:  rd_data = supply_q;
         OFS_WAKE_TIMING:  rd_data = {1'b0, wake_tim_q};
         OFS_WDOG_PERIOD:  rd_data = {1'b0, wdog_sel_q};
         OFS_GND_MONITOR:  rd_data = {txd_sync_q[1], shift_q,
                                      gnd_thr_q};
         OFS_FRAME_ERROR:  rd_data = {3'h0, err_q};
         default:          rd_data = 4'h0;
      endcase
   end

   assign fr.enable     = (mode_q != SBCS_SLEEP)
                        & (mode_q != SBCS_EMERGENCY);
   assign fr.reply_load = fr.head_done
                        & (fr.frame_word[1:0] == RW_READ)
                        & addr_known(fr.frame_word[7:2]);
   assign fr.reply_byte = {sbcs_parity(rd_data), rd_data};

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         head_addr_q <= 6'h00;
      else if (fr.head_done)
         head_addr_q <= fr.frame_word[7:2];
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode registers
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mode_ctrl_q <= MODE_CTRL_RST;
         mode_conf_q <= MODE_CTRL_RST;
         mode_q      <= SBCS_NORMAL_REQ;
      end
      else if (f_wr && mode_code_ok)
      begin
         if (f_addr == OFS_MODE_CONTROL)
            mode_ctrl_q <= f_data[2:0];
         else if (f_addr == OFS_MODE_CONFIRM)
         begin
            mode_conf_q <= f_data[2:0];
            if (f_data[2:0] == mode_ctrl_q)
               mode_q <= sbcs_mode_t'(f_data[2:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         supply_q   <= SUPPLY_RST;
         wake_tim_q <= WAKE_TIMING_RST;
         wdog_sel_q <= WDOG_PERIOD_RST;
         gnd_thr_q  <= GND_THRESH_RST;
      end
      else if (f_wr)
      begin
         case (f_addr)
            OFS_SUPPLY_CTRL: supply_q   <= f_data;
            OFS_WAKE_TIMING: wake_tim_q <= f_data[2:0];
            OFS_WDOG_PERIOD: wdog_sel_q <= f_data[2:0];
            OFS_GND_MONITOR: gnd_thr_q  <= f_data[1:0];
            default:         gnd_thr_q  <= gnd_thr_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags; a new event beats the clear by read
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         gnd_sync_q <= 2'h0;
         txd_sync_q <= 2'h0;
         shift_q    <= 1'b0;
         err_q      <= 1'b0;
      end
      else
      begin
         gnd_sync_q <= {gnd_sync_q[0], GND_SHIFT};
         txd_sync_q <= {txd_sync_q[0], TX_STUCK};
         if (gnd_sync_q[1])
            shift_q <= 1'b1;
         else if (f_rd && f_addr == OFS_GND_MONITOR)
            shift_q <= 1'b0;
         if (f_err)
            err_q <= 1'b1;
         else if (f_rd && f_addr == OFS_FRAME_ERROR)
            err_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog, triggered by a valid write of its period register
   sbcs_window_wdog #(.MS_CYCLES(MS_CYCLES)) u_wdog
   (
      .clk         (MCLK),
      .rst_n       (RST_N),
      .run         ((mode_q == SBCS_NORMAL) |
                    (mode_q == SBCS_STANDBY)),
      .period_sel  (wdog_sel_q),
      .trigger     (f_wr & (f_addr == OFS_WDOG_PERIOD)),
      .expire      (wd_expire),
      .window_open ()
   );

   sbcs_spi_shift u_spi
   (
      .clk     (MCLK),
      .rst_n   (RST_N),
      .sclk    (SCLK),
      .cs_n    (CS_N),
      .mosi    (MOSI),
      .miso    (MISO),
      .miso_oe (MISO_OE),
      .fr      (fr)
   );

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         MODE               <= SBCS_NORMAL_REQ;
         SWITCHED_OUTPUT_ON <= 1'b0;
         CYCLIC_SENSE_ON    <= 1'b0;
         FORCED_WAKE_ON     <= 1'b0;
         WAKE_INPUTS_LINKED <= 1'b1;
         WAKE_PERIOD_SEL    <= WAKE_TIMING_RST;
         GND_THRESHOLD      <= GND_THRESH_RST;
         WDOG_RESET         <= 1'b0;
         SPI_WAKE           <= 1'b0;
         FRAME_ERROR        <= 1'b0;
      end
      else
      begin
         MODE               <= mode_q;
         SWITCHED_OUTPUT_ON <= ((mode_q == SBCS_NORMAL) |
                                (mode_q == SBCS_STANDBY))
                             & supply_q[SUP_ON_BIT]
                             & ~supply_q[SUP_CYCLIC_BIT]
                             & ~supply_q[SUP_FORCED_BIT];
         CYCLIC_SENSE_ON    <= ((mode_q == SBCS_STANDBY) |
                                (mode_q == SBCS_SLEEP))
                             & supply_q[SUP_CYCLIC_BIT];
         FORCED_WAKE_ON     <= (mode_q == SBCS_SLEEP)
                             & supply_q[SUP_FORCED_BIT]
                             & ~supply_q[SUP_CYCLIC_BIT];
         WAKE_INPUTS_LINKED <= supply_q[SUP_LINKED_BIT];
         WAKE_PERIOD_SEL    <= wake_tim_q;
         GND_THRESHOLD      <= gnd_thr_q;
         WDOG_RESET         <= wd_expire;
         SPI_WAKE           <= fr.cs_fall & (mode_q == SBCS_SLEEP);
         FRAME_ERROR        <= err_q;
      end
   end

endmodule
`default_nettype wire

//--- logic/sbcs_pkg.sv
`default_nettype none
package sbcs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Frame layout
   localparam int FRAME_W    = 16;
   localparam int ADDR_MSB   = 15;
   localparam int ADDR_LSB   = 10;
   localparam int RW_MSB     = 9;
   localparam int RW_LSB     = 8;
   localparam int PAR_MSB    = 7;
   localparam int PAR_LSB    = 4;
   localparam int DATA_MSB   = 3;
   localparam int DATA_LSB   = 0;
   localparam logic [3:0] HEAD_LAST  = 4'h7;
   localparam logic [3:0] FRAME_LAST = 4'hf;
   localparam logic [1:0] RW_WRITE   = 2'h3;
   localparam logic [1:0] RW_READ    = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [5:0] OFS_MODE_CONTROL  = 6'h00;
   localparam logic [5:0] OFS_MODE_CONFIRM  = 6'h03;
   localparam logic [5:0] OFS_SUPPLY_CTRL   = 6'h05;
   localparam logic [5:0] OFS_WAKE_TIMING   = 6'h06;
   localparam logic [5:0] OFS_WDOG_PERIOD   = 6'h09;
   localparam logic [5:0] OFS_GND_MONITOR   = 6'h0a;
   localparam logic [5:0] OFS_FRAME_ERROR   = 6'h30;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int SUP_ON_BIT     = 0;
   localparam int SUP_CYCLIC_BIT = 1;
   localparam int SUP_FORCED_BIT = 2;
   localparam int SUP_LINKED_BIT = 3;
   localparam int GND_SHIFT_BIT  = 2;
   localparam int GND_TRANSMIT_STUCK_DOMINANT_BIT  = 3;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [2:0] MODE_CTRL_RST   = 3'h0;
   localparam logic [3:0] SUPPLY_RST      = 4'h8;
   localparam logic [2:0] WAKE_TIMING_RST = 3'h0;
   localparam logic [2:0] WDOG_PERIOD_RST = 3'h0;
   localparam logic [1:0] GND_THRESH_RST  = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_TIME_NS    = 1000000;
   localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
   localparam int DIV_W         = 17;

   typedef enum logic [2:0]
   {
      SBCS_NORMAL_REQ = 3'b000,
      SBCS_NORMAL     = 3'b001,
      SBCS_STANDBY    = 3'b010,
      SBCS_SLEEP      = 3'b100,
      SBCS_EMERGENCY  = 3'b111
   } sbcs_mode_t;

   // Parity over a data nibble
   function automatic logic [3:0] sbcs_parity(input logic [3:0] d);
      sbcs_parity = {d[3] ^ d[0], d[3] ^ d[2], d[2] ^ d[1], d[1] ^ d[0]};
   endfunction

   // Watchdog period in ms
   function automatic logic [7:0] sbcs_wdog_ms(input logic [2:0] sel);
      case (sel)
         3'h0:    sbcs_wdog_ms = 8'h05;
         3'h1:    sbcs_wdog_ms = 8'h0a;
         3'h2:    sbcs_wdog_ms = 8'h14;
         3'h3:    sbcs_wdog_ms = 8'h21;
         3'h4:    sbcs_wdog_ms = 8'h32;
         3'h5:    sbcs_wdog_ms = 8'h4b;
         3'h6:    sbcs_wdog_ms = 8'h64;
         default: sbcs_wdog_ms = 8'hc8;
      endcase
   endfunction

endpackage
`default_nettype wire

//--- logic/sbcs_frame_if.sv
`default_nettype none
interface sbcs_frame_if;
   logic        enable;
   logic        cs_fall;
   logic        head_done;
   logic        frame_done;
   logic        frame_abort;
   logic [15:0] frame_word;
   logic        reply_load;
   logic [7:0]  reply_byte;

   modport shifter
   (
      input  enable,
      input  reply_load,
      input  reply_byte,
      output cs_fall,
      output head_done,
      output frame_done,
      output frame_abort,
      output frame_word
   );

   modport bank
   (
      output enable,
      output reply_load,
      output reply_byte,
      input  cs_fall,
      input  head_done,
      input  frame_done,
      input  frame_abort,
      input  frame_word
   );
endinterface
`default_nettype wire

//--- logic/sbcs_spi_shift.sv
`default_nettype none
module sbcs_spi_shift
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Serial pins
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe,
   // Frame side
   sbcs_frame_if.shifter    fr
);
   import sbcs_pkg::*;

   logic [2:0]  sclk_q;
   logic [2:0]  cs_q;
   logic [1:0]  mosi_q;
   logic [3:0]  bit_cnt_q;
   logic [15:0] rx_q;
   logic [15:0] tx_q;
   logic [15:0] last_q;
   logic        head_q;
   logic        frame_q;
   logic        abort_q;
   logic        csf_q;
   logic        sclk_fall;
   logic        sclk_rise;
   logic        cs_fall;
   logic        cs_rise;
   logic        live;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_q <= 3'h0;
         cs_q   <= 3'h7;
         mosi_q <= 2'h0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], sclk};
         cs_q   <= {cs_q[1:0], cs_n};
         mosi_q <= {mosi_q[0], mosi};
      end
   end

   assign sclk_fall = sclk_q[2] & ~sclk_q[1];
   assign sclk_rise = ~sclk_q[2] & sclk_q[1];
   assign cs_fall   = cs_q[2] & ~cs_q[1];
   assign cs_rise   = ~cs_q[2] & cs_q[1];
   assign live      = ~cs_q[1] & fr.enable;

   ////////////////////////////////////////////////////////////////////////
   // Receive on falling edge, MSB first
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_q      <= 16'h0000;
         bit_cnt_q <= 4'h0;
      end
      else if (cs_fall)
      begin
         bit_cnt_q <= 4'h0;
      end
      else if (live && sclk_fall)
      begin
         rx_q      <= {rx_q[14:0], mosi_q[1]};
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         head_q  <= 1'b0;
         frame_q <= 1'b0;
         abort_q <= 1'b0;
         csf_q   <= 1'b0;
         last_q  <= 16'h0000;
      end
      else
      begin
         head_q  <= live & sclk_fall & (bit_cnt_q == HEAD_LAST);
         frame_q <= live & sclk_fall & (bit_cnt_q == FRAME_LAST);
         abort_q <= cs_rise & fr.enable & (bit_cnt_q != 4'h0);
         csf_q   <= cs_fall;
         if (frame_q)
            last_q <= rx_q;
      end
   end

   assign fr.head_done   = head_q;
   assign fr.frame_done  = frame_q;
   assign fr.frame_abort = abort_q;
   assign fr.frame_word  = rx_q;
   assign fr.cs_fall     = csf_q;

   ////////////////////////////////////////////////////////////////////////
   // Transmit on rising edge; read data replaces the second byte
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_q    <= 16'h0000;
         miso    <= 1'b0;
         miso_oe <= 1'b0;
      end
      else
      begin
         miso_oe <= live;
         if (cs_fall && live && sclk_rise)
         begin
            // First rising edge may be seen together with the select edge
            tx_q <= {last_q[14:0], 1'b0};
            miso <= last_q[15];
         end
         else if (cs_fall)
            tx_q <= last_q;
         else if (fr.reply_load)
            tx_q[15:8] <= fr.reply_byte;
         else if (live && sclk_rise)
         begin
            tx_q <= {tx_q[14:0], 1'b0};
            miso <= tx_q[15];
         end
      end
   end

endmodule
`default_nettype wire

//--- logic/sbcs_window_wdog.sv
`default_nettype none
module sbcs_window_wdog
#(
   parameter int unsigned MS_CYCLES = sbcs_pkg::MS_CYCLES
)
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] period_sel,
   input  wire logic       trigger,
   // Status
   output logic            expire,
   output logic            window_open
);
   import sbcs_pkg::*;

   logic [DIV_W-1:0] div_q;
   logic [7:0]       ms_q;
   logic [7:0]       period;
   logic [7:0]       half;
   logic             tick;

   assign period = sbcs_wdog_ms(period_sel);
   assign half   = {1'b0, period[7:1]};
   assign tick   = (div_q == DIV_W'(MS_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////
   // Millisecond divider and window counter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_q       <= '0;
         ms_q        <= 8'h00;
         expire      <= 1'b0;
         window_open <= 1'b0;
      end
      else if (!run)
      begin
         div_q       <= '0;
         ms_q        <= 8'h00;
         expire      <= 1'b0;
         window_open <= 1'b0;
      end
      else
      begin
         window_open <= (ms_q >= half);
         if (trigger)
         begin
            div_q  <= '0;
            ms_q   <= 8'h00;
            expire <= (ms_q < half);
         end
         else if (tick)
         begin
            div_q <= '0;
            if (ms_q + 8'h01 >= period)
            begin
               ms_q   <= 8'h00;
               expire <= 1'b1;
            end
            else
            begin
               ms_q   <= ms_q + 8'h01;
               expire <= 1'b0;
            end
         end
         else
         begin
            div_q  <= div_q + DIV_W'(1);
            expire <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

//--- sim/sbcs_bank_props.sv
`default_nettype none
module sbcs_bank_props
#(
   parameter int unsigned MS_CYCLES = 10
)
(
   // Clock and reset
   input wire logic       MCLK,
   input wire logic       RST_N,
   // Serial link
   input wire logic       CS_N,
   input wire logic       MISO_OE,
   // Levels
   input wire logic [2:0] MODE,
   input wire logic       SWITCHED_OUTPUT_ON,
   input wire logic       CYCLIC_SENSE_ON,
   input wire logic       FORCED_WAKE_ON,
   input wire logic       WAKE_INPUTS_LINKED,
   input wire logic [2:0] WAKE_PERIOD_SEL,
   input wire logic [1:0] GND_THRESHOLD,
   // Events
   input wire logic       WDOG_RESET,
   input wire logic       SPI_WAKE,
   input wire logic       FRAME_ERROR
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   reset_vals_a: assert property (
      $rose(RST_N) |-> MODE == 3'h0 && WAKE_INPUTS_LINKED && !FRAME_ERROR)
      else $error("outputs wrong after reset");
   oe_idle_a: assert property (CS_N [*8] |-> !MISO_OE)
      else $error("output driven while deselected");
   oe_sleep_a: assert property (
      MODE inside {3'h4, 3'h7} && $stable(MODE) |-> !MISO_OE)
      else $error("output driven in low power mode");
   mode_legal_a: assert property (
      MODE inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h7})
      else $error("illegal mode");
   sup_gate_a: assert property (SWITCHED_OUTPUT_ON |->
      MODE inside {3'h1, 3'h2} && !CYCLIC_SENSE_ON && !FORCED_WAKE_ON)
      else $error("switched output on wrongly");
   forced_gate_a: assert property (
      FORCED_WAKE_ON |-> MODE == 3'h4 && !CYCLIC_SENSE_ON)
      else $error("forced wake outside sleep");
   regs_hold_a: assert property (CS_N [*8] |=> $stable({MODE,
      WAKE_INPUTS_LINKED, WAKE_PERIOD_SEL, GND_THRESHOLD}))
      else $error("state changed without a frame");
   wdog_mode_a: assert property (WDOG_RESET |->
      MODE inside {3'h1, 3'h2} || $past(MODE) inside {3'h1, 3'h2})
      else $error("watchdog fired in stopped mode");
   wake_sleep_a: assert property (
      SPI_WAKE |-> MODE == 3'h4 || $past(MODE) == 3'h4)
      else $error("serial wake outside sleep");
   err_sticky_a: assert property (
      (FRAME_ERROR && CS_N) [*8] |=> FRAME_ERROR)
      else $error("error flag lost without a read");

   cover property (MODE == 3'h1);
   cover property (MODE == 3'h4 && SPI_WAKE);
   cover property (WDOG_RESET);
   cover property ($rose(FRAME_ERROR));
endmodule
`default_nettype wire

//--- sim/sbcs_spi_master.sv
`default_nettype none
module sbcs_spi_master
(
   // Serial pins
   output logic        sclk,
   output logic        cs_n,
   output logic        mosi,
   input  wire logic   miso,
   // Read result
   output logic        done,
   output logic [15:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      done = 1'b0;
      rx   = 16'h0;
   end

   // One frame MSB first; clock parked low outside frames
   task automatic xfer(input logic [15:0] w);
      cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         mosi = w[i];
         #5 sclk = 1'b1;
         #40 sclk = 1'b0;
         #35 rx[i] = miso;
      end
      cs_n = 1'b1;
      mosi = ~mosi;
      if (w[9:8] == 2'h0)
         done = ~done;
      #60;
   endtask
endmodule
`default_nettype wire

//--- sim/sbcs_bank_top_bench.sv
`default_nettype none
module sbcs_bank_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sbcs_pkg::*;

   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        gnd_shift = 1'b0;
   logic        tx_stuck = 1'b0;
   logic        sclk, cs_n, mosi, miso, miso_oe, done;
   logic        sup_on, cyc_on, fwu_on, linked, wdog, wake, ferr;
   logic [15:0] rx, g;
   logic [2:0]  mode, wsel;
   logic [1:0]  thr;
   logic [3:0]  d;
   logic [7:0]  exp_q[$];
   logic [15:0] flips[5] = '{16'h0001, 16'h0010, 16'h0100, 16'h0200,
                             16'h0400};
   int          error_cnt = 0, samples_checked = 0, cycles = 0;
   int          wdog_cnt = 0, wake_cnt = 0;
   int          seed = 32'h9b00;

   always #5 mclk = ~mclk;

   sbcs_bank_top #(.MS_CYCLES(20)) DUT
   (
      .MCLK(mclk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi),
      .MISO(miso), .MISO_OE(miso_oe), .GND_SHIFT(gnd_shift),
      .TX_STUCK(tx_stuck), .MODE(mode), .SWITCHED_OUTPUT_ON(sup_on),
      .CYCLIC_SENSE_ON(cyc_on), .FORCED_WAKE_ON(fwu_on),
      .WAKE_INPUTS_LINKED(linked), .WAKE_PERIOD_SEL(wsel),
      .GND_THRESHOLD(thr), .WDOG_RESET(wdog), .SPI_WAKE(wake),
      .FRAME_ERROR(ferr)
   );

   sbcs_spi_master m
   (
      .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .done(done),
      .rx(rx)
   );

   task automatic wrap_up();
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
      end
   endtask

   function automatic logic [3:0] par(input logic [3:0] v);
      return {v[3] ^ v[0], v[3] ^ v[2], v[2] ^ v[1], v[1] ^ v[0]};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [5:0] a, input logic [3:0] v);
      m.xfer({a, 2'h3, par(v), v});
   endtask

   task automatic rd(input logic [5:0] a, input logic [3:0] v);
      exp_q.push_back({par(v), v});
      m.xfer({a, 2'h0, 8'h0});
   endtask

   // Read replies are compared in order of issue
   always @(done)
      if (rst_n)
         chk(rx[7:0], exp_q.pop_front());

   always @(posedge mclk)
   begin
      cycles++;
      if (wdog === 1'b1)
         wdog_cnt++;
      if (wake === 1'b1)
         wake_cnt++;
      if (cycles == 40000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   initial
   begin
      tick(8);
      rst_n = 1'b1;
      tick(4);
      chk(8'(mode), 8'h0);
      chk(8'(linked), 8'h1);
      rd(OFS_MODE_CONTROL, 4'h0);
      rd(OFS_MODE_CONFIRM, 4'h0);
      rd(OFS_SUPPLY_CTRL, 4'h8);
      rd(OFS_WAKE_TIMING, 4'h0);
      rd(OFS_WDOG_PERIOD, 4'h0);
      rd(OFS_GND_MONITOR, 4'h0);
      rd(6'h01, 4'h0);
      tick(10);
      chk(8'(ferr), 8'h1);
      rd(OFS_FRAME_ERROR, 4'h1);
      chk(8'(ferr), 8'h0);
      for (int i = 0; i < 4; i++)
      begin
         d = 4'($random(seed));
         tx_stuck = d[3];
         wr(OFS_WAKE_TIMING, d);
         wr(OFS_GND_MONITOR, d);
         chk(8'(wsel), 8'(d[2:0]));
         chk(8'(thr), 8'(d[1:0]));
         rd(OFS_GND_MONITOR, {d[3], 1'b0, d[1:0]});
      end
      gnd_shift = 1'b1;
      tick(5);
      gnd_shift = 1'b0;
      rd(OFS_GND_MONITOR, {d[3], 1'b1, d[1:0]});
      rd(OFS_GND_MONITOR, {d[3], 1'b0, d[1:0]});
      // Each corrupted frame must leave the register alone
      g = {OFS_WAKE_TIMING, 2'h3, par(~d), ~d};
      for (int i = 0; i < 5; i++)
      begin
         m.xfer(g ^ flips[i]);
         chk(8'(wsel), 8'(d[2:0]));
         chk(8'(ferr), 8'h1);
         rd(OFS_FRAME_ERROR, 4'h1);
      end
      wr(OFS_SUPPLY_CTRL, 4'h1);
      chk(8'(linked), 8'h0);
      wr(OFS_MODE_CONTROL, 4'h1);
      chk(8'(mode), 8'h0);
      wr(OFS_MODE_CONFIRM, 4'h1);
      chk(8'(mode), 8'h1);
      chk(8'(sup_on), 8'h1);
      rd(OFS_MODE_CONFIRM, 4'h1);
      wr(OFS_MODE_CONTROL, 4'h3);
      wr(OFS_MODE_CONFIRM, 4'h3);
      chk(8'(mode), 8'h1);
      wr(OFS_MODE_CONTROL, 4'h2);
      wr(OFS_MODE_CONFIRM, 4'h4);
      chk(8'(mode), 8'h1);
      wr(OFS_SUPPLY_CTRL, 4'h3);
      chk(8'(sup_on), 8'h0);
      wr(OFS_WDOG_PERIOD, 4'h7);
      tick(20);
      wdog_cnt = 0;
      tick(1500);
      wr(OFS_WDOG_PERIOD, 4'h7);
      tick(20);
      chk(8'(wdog_cnt), 8'h1);
      tick(2500);
      wdog_cnt = 0;
      wr(OFS_WDOG_PERIOD, 4'h7);
      tick(20);
      chk(8'(wdog_cnt), 8'h0);
      wr(OFS_MODE_CONTROL, 4'h2);
      wr(OFS_MODE_CONFIRM, 4'h2);
      chk(8'(cyc_on), 8'h1);
      wr(OFS_SUPPLY_CTRL, 4'h4);
      wr(OFS_MODE_CONTROL, 4'h4);
      wr(OFS_MODE_CONFIRM, 4'h4);
      chk(8'(fwu_on), 8'h1);
      wdog_cnt = 0;
      wr(OFS_WAKE_TIMING, ~d);
      tick(5000);
      chk(8'(wsel), 8'(d[2:0]));
      chk(8'(wdog_cnt), 8'h0);
      chk(8'(wake_cnt), 8'h1);
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(4);
      chk(8'(mode), 8'h0);
      chk(8'(linked), 8'h1);
      wr(OFS_MODE_CONTROL, 4'h7);
      wr(OFS_MODE_CONFIRM, 4'h7);
      chk(8'(mode), 8'h7);
      wr(OFS_WAKE_TIMING, 4'h5);
      chk(8'(wsel), 8'h0);
      wrap_up();
   end
endmodule

bind sbcs_bank_top sbcs_bank_props #(.MS_CYCLES(MS_CYCLES)) u_props
(
   .MCLK, .RST_N, .CS_N, .MISO_OE, .MODE, .SWITCHED_OUTPUT_ON,
   .CYCLIC_SENSE_ON, .FORCED_WAKE_ON, .WAKE_INPUTS_LINKED,
   .WAKE_PERIOD_SEL, .GND_THRESHOLD, .WDOG_RESET, .SPI_WAKE, .FRAME_ERROR
);
`default_nettype wire
